// file: pcr_pkg.sv
// Purpose: shared constants and types for the power-up configuration loader
// Assumes: one 40 MHz clock, asynchronous active-high power-on reset
// Notes:   behaviour summary below; lamp and switch levels active high
//
// Behaviour
// - factory defaults are uncoded beams, restart interlock off, contactor monitor off.
// - restart interlock or contactor monitor changes refused unless factory reset came first.
// - beam coding and other functions may change at any power-up without reset.
// - each unit runs the reset sequence alone; role only picks a lamp.
// - both switches on, set while unpowered, request a factory reset.
// - during the reset window field lamp alternates yellow and green.
// - next power-up with switches off confirms reset by flashing field lamp green.
// - then transmitter lights state lamp red, receiver lights safety output lamp red.
// - switches off/off uncoded, on/off code 1, off/on code 2, on/on reset.
// - configuration mode ends only by a supply interruption.
package pcr_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ     = 64'd40_000_000;
  localparam longint unsigned WINDOW_MS  = 64'd10_000;
  localparam longint unsigned FLASH_MS   = 64'd250;
  // longest time, so round down
  localparam int unsigned     WINDOW_CYC = 32'(WINDOW_MS * CLK_HZ / 64'd1000);
  localparam int unsigned     FLASH_CYC  = 32'(FLASH_MS * CLK_HZ / 64'd1000);
  localparam int              TMR_W      = 29;
  localparam int              FLS_W      = 24;

  // ----------------------------------------------------------------
  // switch encoding
  // ----------------------------------------------------------------
  localparam logic [1:0] SW_UNCODED = 2'h0;
  localparam logic [1:0] SW_RESET   = 2'h3;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam int         ADDR_W     = 4;
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STAT_OFS   = 4'h4;
  localparam int         CTRL_RI    = 0;
  localparam int         CTRL_CF    = 1;
  localparam int         STAT_REF   = 7;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;

  typedef enum logic [1:0] {PCR_OFF, PCR_ARMED, PCR_RUN, PCR_CFG} pcr_mode_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } pcr_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pcr_axi_rsp_t;

  typedef struct packed {
    logic field_green;
    logic field_yellow;
    logic state_red;
    logic safety_red;
  } pcr_lamp_t;

  typedef struct packed {
    logic [1:0] beam_code;
    logic       restart_cfg;
    logic       cfb_cfg;
  } pcr_cfg_t;

endpackage : pcr_pkg

// file: pcr_loader.sv
// Purpose: power-up switch sampling, factory reset sequence, config locks
// Assumes: supply_ok and switches are asynchronous pins
// Notes:   settings survive supply loss; rst or a confirmed factory reset clears them
`timescale 1ns/100ps
`default_nettype none

module pcr_loader
  import pcr_pkg::*;
#(
  parameter int unsigned WIN_CYC = WINDOW_CYC,
  parameter int unsigned FLS_CYC = FLASH_CYC
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         supply_ok,
  input  wire logic         cfg_switch_1,
  input  wire logic         cfg_switch_2,
  input  wire logic         unit_is_receiver,
  input  wire pcr_axi_req_t axi_req,
  output wire pcr_axi_rsp_t axi_rsp,
  output wire pcr_lamp_t    lamps,
  output wire pcr_cfg_t     cfg_out,
  output wire logic         config_mode
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]        sync1;
    logic [3:0]        sync2;
    logic              supply_prev;
    pcr_mode_t         mode;
    logic [TMR_W-1:0]  timer;
    logic [FLS_W-1:0]  flash_cnt;
    logic              flash_ph;
    logic              armed;
    logic              cfg_open;
    pcr_cfg_t          cfg;
    logic              refused;
    pcr_lamp_t         lamps;
    logic              cfg_mode;
    pcr_axi_rsp_t      rsp;
    logic              aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_got;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
  } pcr_state_t;

  pcr_state_t st_reg;
  pcr_state_t st_next;
  logic       sup;
  logic [1:0] sw;
  logic       role;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == CTRL_OFS) || (a == STAT_OFS);
  endfunction : is_mapped

  function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a, input pcr_state_t s);
    logic [31:0] d;
    d = 32'h0;
    if (a == CTRL_OFS) begin
      d[CTRL_RI] = s.cfg.restart_cfg;
      d[CTRL_CF] = s.cfg.cfb_cfg;
    end else if (a == STAT_OFS) begin
      d[8:0] = {s.sync2[0], s.refused, s.armed, s.cfg.cfb_cfg, s.cfg.restart_cfg,
                s.cfg.beam_code, s.mode};
    end
    return d;
  endfunction : rd_word

  assign sup  = st_reg.sync2[3];
  assign sw   = st_reg.sync2[2:1];
  assign role = st_reg.sync2[0];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next             = st_reg;
    st_next.sync1       = {supply_ok, cfg_switch_2, cfg_switch_1, unit_is_receiver};
    st_next.sync2       = st_reg.sync1;
    st_next.supply_prev = sup;

    if (st_reg.flash_cnt == FLS_W'(FLS_CYC - 1)) begin
      st_next.flash_cnt = '0;
      st_next.flash_ph  = ~st_reg.flash_ph;
    end else begin
      st_next.flash_cnt = st_reg.flash_cnt + FLS_W'(1);
    end

    unique case (st_reg.mode)
      PCR_OFF: begin
        if (sup && !st_reg.supply_prev) begin
          if (sw == SW_RESET) begin
            st_next.mode  = PCR_ARMED;
            st_next.timer = '0;
          end else if (st_reg.armed) begin
            st_next.cfg.beam_code   = SW_UNCODED;
            st_next.cfg.restart_cfg = 1'b0;
            st_next.cfg.cfb_cfg     = 1'b0;
            st_next.armed           = 1'b0;
            st_next.cfg_open        = 1'b1;
            st_next.mode            = PCR_CFG;
          end else begin
            st_next.cfg.beam_code = sw;
            st_next.mode          = PCR_RUN;
          end
        end
      end
      PCR_ARMED: begin
        if (!sup) begin
          st_next.armed = 1'b1;
          st_next.mode  = PCR_OFF;
        end else if (st_reg.timer == TMR_W'(WIN_CYC - 1)) begin
          // drop the request so a later power-up runs normally
          st_next.armed = 1'b0;
          st_next.mode  = PCR_RUN;
        end else begin
          st_next.timer = st_reg.timer + TMR_W'(1);
        end
      end
      PCR_RUN: begin
        if (!sup) st_next.mode = PCR_OFF;
      end
      PCR_CFG: begin
        // no other exit: config mode is left only through the supply
        if (!sup) begin
          st_next.mode     = PCR_OFF;
          st_next.cfg_open = 1'b0;
        end
      end
    endcase

    // write channel, address and data taken in either order
    if (axi_req.awvalid && st_reg.rsp.awready) begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_reg.rsp.wready) begin
      st_next.w_got  = 1'b1;
      st_next.w_data = axi_req.wdata;
      st_next.w_strb = axi_req.wstrb;
    end
    if (st_reg.rsp.bvalid && axi_req.bready) st_next.rsp.bvalid = 1'b0;
    if (st_reg.aw_got && st_reg.w_got && !st_reg.rsp.bvalid) begin
      st_next.aw_got     = 1'b0;
      st_next.w_got      = 1'b0;
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp  = is_mapped(st_reg.aw_addr) ? RESP_OKAY : RESP_SLV;
      if (st_reg.aw_addr == STAT_OFS && st_reg.w_strb[0] && st_reg.w_data[STAT_REF])
        st_next.refused = 1'b0;
      if (st_reg.aw_addr == CTRL_OFS && st_reg.w_strb[0] &&
          (st_reg.w_data[CTRL_RI] || st_reg.w_data[CTRL_CF])) begin
        // lock opens only in config mode entered through a factory reset
        if (st_reg.mode == PCR_CFG && st_reg.cfg_open) begin
          if (st_reg.w_data[CTRL_RI]) st_next.cfg.restart_cfg = 1'b1;
          if (st_reg.w_data[CTRL_CF]) st_next.cfg.cfb_cfg = 1'b1;
        end else begin
          st_next.refused = 1'b1;
        end
      end
    end
    st_next.rsp.awready = !st_next.aw_got && !st_next.rsp.bvalid;
    st_next.rsp.wready  = !st_next.w_got && !st_next.rsp.bvalid;

    // read channel
    if (st_reg.rsp.rvalid && axi_req.rready) st_next.rsp.rvalid = 1'b0;
    if (axi_req.arvalid && st_reg.rsp.arready) begin
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rdata  = rd_word(axi_req.araddr, st_reg);
      st_next.rsp.rresp  = is_mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLV;
    end
    st_next.rsp.arready = !st_next.rsp.rvalid;

    // lamps follow the next mode so they change with it
    st_next.lamps = '0;
    unique case (st_next.mode)
      PCR_OFF: st_next.lamps = '0;
      PCR_ARMED: begin
        st_next.lamps.field_green  = st_next.flash_ph;
        st_next.lamps.field_yellow = !st_next.flash_ph;
      end
      PCR_RUN: st_next.lamps.field_green = 1'b1;
      PCR_CFG: begin
        st_next.lamps.field_green = st_next.flash_ph;
        // role picks the lamp only; no link to the far unit is needed
        st_next.lamps.state_red   = !role;
        st_next.lamps.safety_red  = role;
      end
    endcase
    st_next.cfg_mode = (st_next.mode == PCR_CFG);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign axi_rsp     = st_reg.rsp;
  assign lamps       = st_reg.lamps;
  assign cfg_out     = st_reg.cfg;
  assign config_mode = st_reg.cfg_mode;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  defaults_load_a: assert property ($rose(config_mode) |->
    cfg_out.beam_code == SW_UNCODED && !cfg_out.restart_cfg && !cfg_out.cfb_cfg)
    else $error("defaults not loaded on reset entry");
  lock_refuse_a: assert property (
    st_reg.aw_got && st_reg.w_got && !st_reg.rsp.bvalid && st_reg.aw_addr == CTRL_OFS
    && st_reg.w_strb[0] && st_reg.w_data[CTRL_RI] && !(st_reg.mode == PCR_CFG
    && st_reg.cfg_open) |=> st_reg.refused && $stable(cfg_out.restart_cfg))
    else $error("locked setting changed");
  code_load_a: assert property (
    st_reg.mode == PCR_OFF && sup && !st_reg.supply_prev && sw != SW_RESET
    && !st_reg.armed |=> st_reg.mode == PCR_RUN && cfg_out.beam_code == $past(sw))
    else $error("beam code not taken from switches");
  arm_request_a: assert property (
    st_reg.mode == PCR_OFF && sup && !st_reg.supply_prev && sw == SW_RESET
    |=> st_reg.mode == PCR_ARMED && (lamps.field_green != lamps.field_yellow))
    else $error("reset request not armed");
  window_flash_a: assert property (st_reg.mode == PCR_ARMED |->
    lamps.field_green != lamps.field_yellow && !lamps.state_red)
    else $error("window lamps not alternating");
  confirm_lamp_a: assert property (config_mode |->
    !lamps.field_yellow && (lamps.safety_red == $past(role))
    && (lamps.state_red == !$past(role)))
    else $error("confirm lamps wrong");
  cfg_hold_a: assert property (config_mode && sup |=> config_mode)
    else $error("config mode left with supply on");
  abandon_a: assert property (
    st_reg.mode == PCR_ARMED && sup && st_reg.timer == TMR_W'(WIN_CYC - 1)
    |=> st_reg.mode == PCR_RUN && !st_reg.armed && $stable(cfg_out))
    else $error("stale reset not abandoned");
  resp_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped early");
  rd_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata) && $stable(axi_rsp.rresp))
    else $error("read response dropped early");
  // no new request may be taken while its answer is pending
  wr_block_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while response pending");
  rd_block_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken while response pending");

  // ----------------------------------------------------------------
  // lock, reset window and lamp checks
  // ----------------------------------------------------------------
  cfb_refuse_a: assert property (
    st_reg.aw_got && st_reg.w_got && !st_reg.rsp.bvalid && st_reg.aw_addr == CTRL_OFS
    && st_reg.w_strb[0] && st_reg.w_data[CTRL_CF] && !(st_reg.mode == PCR_CFG
    && st_reg.cfg_open) |=> st_reg.refused && $stable(cfg_out.cfb_cfg))
    else $error("locked monitor setting changed");
  lock_accept_a: assert property (
    st_reg.aw_got && st_reg.w_got && !st_reg.rsp.bvalid && st_reg.aw_addr == CTRL_OFS
    && st_reg.w_strb[0] && st_reg.w_data[CTRL_RI] && st_reg.mode == PCR_CFG
    && st_reg.cfg_open |=> cfg_out.restart_cfg)
    else $error("unlocked setting not taken");
  refused_hold_a: assert property (st_reg.refused && !(st_reg.aw_got
    && st_reg.w_got && st_reg.aw_addr == STAT_OFS) |=> st_reg.refused)
    else $error("refused flag lost");
  run_hold_a: assert property (st_reg.mode == PCR_RUN |=> $stable(cfg_out))
    else $error("settings changed outside power-up");
  armed_clear_a: assert property ($rose(config_mode) |->
    !st_reg.armed && st_reg.cfg_open)
    else $error("reset request left armed");
  window_len_a: assert property (st_reg.mode == PCR_ARMED |->
    st_reg.timer < TMR_W'(WIN_CYC))
    else $error("reset window overran");
  red_cfg_a: assert property (!config_mode |->
    !lamps.state_red && !lamps.safety_red)
    else $error("red lamp outside config mode");
  off_dark_a: assert property (st_reg.mode == PCR_OFF |-> lamps == '0)
    else $error("lamp lit while unpowered");


  arm_seen_c:    cover property (st_reg.mode == PCR_ARMED ##1 st_reg.armed);
  reset_done_c:  cover property ($rose(config_mode));
  abandon_c:     cover property (st_reg.mode == PCR_ARMED ##1 st_reg.mode == PCR_RUN);
  refused_c:     cover property ($rose(st_reg.refused));
  lock_open_c:   cover property ($rose(cfg_out.cfb_cfg));

endmodule : pcr_loader

`default_nettype wire

// file: pcr_installer.sv
// Purpose: installer model driving supply and config switches
// Assumes: bench commands power and switch positions
// Notes:   switches move only while the unit is unpowered
`timescale 1ns/100ps
`default_nettype none

module pcr_installer (
  input  wire logic       ref_clk,
  input  wire logic [1:0] sw_cmd,
  input  wire logic       power_cmd,
  output var  logic       supply_ok,
  output var  logic       cfg_switch_1,
  output var  logic       cfg_switch_2
);
  // ------------------------------------------------
  // supply and switches
  // ------------------------------------------------
  initial begin
    supply_ok = 1'b0;
    cfg_switch_1 = 1'b0;
    cfg_switch_2 = 1'b0;
  end

  always @(posedge ref_clk) begin
    if (!supply_ok) begin
      cfg_switch_1 <= sw_cmd[0];
      cfg_switch_2 <= sw_cmd[1];
    end
    supply_ok <= power_cmd;
  end
endmodule : pcr_installer
`default_nettype wire

// file: pcr_loader_tb_top.sv
// Purpose: self-checking bench for the power-up config loader
// Assumes: window and flash counts shortened below
// Notes:   installer model owns supply and switch pins
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end

module pcr_loader_tb_top;
  import pcr_pkg::*;
  localparam int unsigned WIN = 40;
  localparam int unsigned FLS = 4;
  logic         ref_clk = 1'b0;
  logic         rst = 1'b1;
  logic         power_cmd = 1'b0;
  logic [1:0]   sw_cmd = 2'h0;
  logic         unit_is_receiver = 1'b0;
  pcr_axi_req_t req = '0;
  pcr_axi_rsp_t rsp;
  pcr_lamp_t    lamps;
  pcr_cfg_t     cfg_out;
  logic         config_mode;
  wire logic    supply_ok;
  wire logic    sw1;
  wire logic    sw2;
  int           miscompares = 0;
  int           n_tests = 0;
  logic [31:0]  rd;
  logic [1:0]   rs;

  always #12.5 ref_clk = ~ref_clk;

  pcr_installer pcr_installer_inst (.ref_clk(ref_clk), .sw_cmd(sw_cmd), .power_cmd(power_cmd),
    .supply_ok(supply_ok), .cfg_switch_1(sw1), .cfg_switch_2(sw2));
  pcr_loader #(.WIN_CYC(WIN), .FLS_CYC(FLS)) pcr_loader_inst (.ref_clk(ref_clk), .rst(rst),
    .supply_ok(supply_ok), .cfg_switch_1(sw1), .cfg_switch_2(sw2),
    .unit_is_receiver(unit_is_receiver), .axi_req(req), .axi_rsp(rsp), .lamps(lamps),
    .cfg_out(cfg_out), .config_mode(config_mode));

  // ------------------------------------------------
  // bus and power tasks
  // ------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  // ready sampled at negedge, so it is settled before the taking edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    logic b;
    @(posedge ref_clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(negedge ref_clk);
      aw = req.awvalid & rsp.awready;
      w = req.wvalid & rsp.wready;
      b = rsp.bvalid;
      r = rsp.bresp;
      @(posedge ref_clk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end while (b !== 1'b1);
    req.bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar;
    logic h;
    @(posedge ref_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(negedge ref_clk);
      ar = req.arvalid & rsp.arready;
      h = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge ref_clk);
      if (ar) req.arvalid <= 1'b0;
    end while (h !== 1'b1);
    req.rready <= 1'b0;
  endtask : rdr

  task automatic pwr(input logic on, input logic [1:0] sw, input int n);
    @(posedge ref_clk);
    power_cmd <= on;
    sw_cmd <= sw;
    cyc(n);
  endtask : pwr

  task automatic watch(input int n, output int y, output int g, output int yg);
    y = 0;
    g = 0;
    yg = 0;
    repeat (n) begin
      @(negedge ref_clk);
      if (lamps.field_yellow === 1'b1) y++;
      if (lamps.field_green === 1'b1) g++;
      if (lamps.field_yellow === 1'b1 && lamps.field_green === 1'b1) yg++;
    end
  endtask : watch

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_defaults;
    `CHK("cfg", 4'h0, cfg_out)
    rdr(STAT_OFS, rd, rs);
    `CHK("stat", 9'h000, rd[8:0])
    `CHK("rresp_ok", RESP_OKAY, rs)
  endtask : t_defaults

  task automatic t_codes;
    for (int i = 0; i < 3; i++) begin
      pwr(1'b0, 2'(i), 6);
      pwr(1'b1, 2'(i), 8);
      `CHK("beam", 2'(i), cfg_out.beam_code)
      rdr(STAT_OFS, rd, rs);
      `CHK("mode", 2'h2, rd[1:0])
    end
  endtask : t_codes

  task automatic t_refuse;
    wr(CTRL_OFS, 32'h3, rs);
    `CHK("bresp_ok", RESP_OKAY, rs)
    `CHK("lock", 4'h8, {cfg_out.beam_code, cfg_out.restart_cfg, cfg_out.cfb_cfg})
    rdr(STAT_OFS, rd, rs);
    `CHK("refused", 1'b1, rd[STAT_REF])
    wr(STAT_OFS, 32'h80, rs);
    rdr(STAT_OFS, rd, rs);
    `CHK("clear", 1'b0, rd[STAT_REF])
    wr(4'h8, 32'h0, rs);
    `CHK("bresp", RESP_SLV, rs)
    rdr(4'hC, rd, rs);
    `CHK("rresp", RESP_SLV, rs)
  endtask : t_refuse

  // whole power is held well inside the shortened window
  task automatic t_reset(input logic role);
    int y;
    int g;
    int b;
    @(posedge ref_clk);
    unit_is_receiver <= role;
    pwr(1'b0, 2'h3, 6);
    pwr(1'b1, 2'h3, 8);
    rdr(STAT_OFS, rd, rs);
    `CHK("armed_mode", 2'h1, rd[1:0])
    watch(16, y, g, b);
    `CHK("alt", 3'h7, {y > 0, g > 0, b == 0})
    pwr(1'b0, 2'h3, 8);
    rdr(STAT_OFS, rd, rs);
    `CHK("armed", 1'b1, rd[6])
    pwr(1'b0, 2'h0, 6);
    pwr(1'b1, 2'h0, 8);
    `CHK("cfg_mode", 1'b1, config_mode)
    `CHK("defaults", 4'h0, cfg_out)
    watch(16, y, g, b);
    `CHK("green", 2'h3, {g > 0, g < 16})
    `CHK("red", {~role, role}, {lamps.state_red, lamps.safety_red})
    wr(CTRL_OFS, 32'h3, rs);
    `CHK("locks", 3'h7, {config_mode, cfg_out.restart_cfg, cfg_out.cfb_cfg})
    pwr(1'b0, 2'h0, 6);
    `CHK("leave", 1'b0, config_mode)
    pwr(1'b1, 2'h0, 8);
    `CHK("run", 3'h3, {config_mode, cfg_out.restart_cfg, cfg_out.cfb_cfg})
  endtask : t_reset

  task automatic t_abandon;
    pwr(1'b0, 2'h3, 6);
    pwr(1'b1, 2'h3, 8);
    pwr(1'b0, 2'h3, 8);
    pwr(1'b1, 2'h3, WIN + 20);
    rdr(STAT_OFS, rd, rs);
    `CHK("abandon", 3'h4, {rd[1:0], rd[6]})
    `CHK("kept", 4'h3, cfg_out)
    pwr(1'b0, 2'h0, 6);
    pwr(1'b1, 2'h0, 8);
    `CHK("no_cfg", 1'b0, config_mode)
  endtask : t_abandon

  task automatic complete_run;
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  initial begin
    cyc(5000);
    miscompares++;
    complete_run();
  end

  initial begin
    cyc(16);
    rst <= 1'b0;
    cyc(2);
    t_defaults();
    t_codes();
    t_refuse();
    t_reset(1'b0);
    t_reset(1'b1);
    t_abandon();
    complete_run();
  end
endmodule : pcr_loader_tb_top
`default_nettype wire
